/* hdl/recovery_cmd.v */
// Summary of operation
// - A frame of "14" then twelve data bytes is taken as the recovery set request.
// - Data bytes hold outputs one to ten in order, 0x31 enabling and 0x32 disabling.
// - Comma bytes 0x2C sit after output four and after output eight.
// - The set request is answered with "15" and thirteen data bytes, flag then settings.
// - The flag is 0x30 when accepted, 0x31 in run mode and 0x39 when malformed.
// - The query is "16" followed by one dummy byte 0x30.
// - The query answer uses the same format with flag 0x30.
// - After reset recovery is enabled for every output.
// - The run mode flag is reported while the device is not in setting mode.
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`include "recovery_cmd_map.vh"
module recovery_cmd (
	input  wire       REF_CLK,
	input  wire       RESET_N,
	input  wire       CLK_EN,
	input  wire [7:0] RX_DATA,
	input  wire       RX_VALID,
	output reg  [7:0] TX_DATA,
	output reg        TX_VALID,
	input  wire       TX_READY,
	input  wire       SETUP_MODE_PIN,
	input  wire       POWER_GOOD_PIN,
	output reg  [9:0] OUTPUTS,
	input  wire [3:0] REG_ADDR,
	input  wire [9:0] REG_WDATA,
	input  wire       REG_WR,
	input  wire       REG_RD,
	output reg  [9:0] REG_RDATA
);
	// ****************************************************************
	// states
	// ****************************************************************
	localparam ST_CODE0 = 3'h0;
	localparam ST_CODE1 = 3'h1;
	localparam ST_SETD  = 3'h2;
	localparam ST_QRYD  = 3'h3;
	localparam ST_RESP  = 3'h4;

	reg  [2:0] state_q;
	reg  [3:0] cnt_q;
	reg  [9:0] recov_q;
	reg  [9:0] shadow_q;
	reg        bad_q;
	reg  [7:0] flag_q;
	reg  [9:0] out_state_q;
	reg  [9:0] default_q;
	reg        pg_prev_q;
	reg  [7:0] frames_q;
	reg        setup_reg_q;
	reg        use_pin_q;
	reg  [9:0] shadow_d;
	reg  [7:0] flag_d;

	wire       setup_sync;
	wire       pg_sync;
	wire       setting_mode;
	wire [7:0] rsp_byte;
	wire [3:0] slot;
	wire       sep_slot;
	wire       val_ok;
	wire [3:0] bit_idx;
	wire       pg_rise;

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	sync2 #(
		.W (2)
	) u_sync (
		.clk (REF_CLK),
		.ce  (CLK_EN),
		.d   ({SETUP_MODE_PIN, POWER_GOOD_PIN}),
		.q   ({setup_sync, pg_sync})
	);

	// setting mode from pin or from register override
	assign setting_mode = use_pin_q ? setup_sync : setup_reg_q;

	// power good rising edge, idle high after reset
	assign pg_rise = pg_sync && !pg_prev_q;

	// ****************************************************************
	// set data decode
	// ****************************************************************
	assign slot     = cnt_q;
	assign sep_slot = (slot == `SEP_POS_A) || (slot == `SEP_POS_B);
	assign val_ok   = (RX_DATA == `VAL_ENABLE) || (RX_DATA == `VAL_DISABLE);
	assign bit_idx  = (slot < `SEP_POS_A) ? slot :
	                  (slot < `SEP_POS_B) ? slot - 4'h1 : slot - 4'h2;

	// ****************************************************************
	// shadow settings with the current data byte applied
	// ****************************************************************
	always @* begin
		shadow_d = shadow_q;
		if (!sep_slot && val_ok && (slot < `SET_DATA_LEN)) begin
			shadow_d[bit_idx] = (RX_DATA == `VAL_ENABLE);
		end
	end

	// ****************************************************************
	// result flag of a completed set frame
	// ****************************************************************
	always @* begin
		flag_d = `FLAG_OK;
		if (!setting_mode) begin
			flag_d = `FLAG_RUN_MODE;
		end else if (bad_q || (!sep_slot && !val_ok)) begin
			flag_d = `FLAG_FAIL;
		end
	end

	resp_builder u_resp (
		.idx      (cnt_q),
		.flag     (flag_q),
		.recov    (recov_q),
		.byte_out (rsp_byte)
	);

	// ****************************************************************
	// frame parser and responder
	// ****************************************************************
	always @(posedge REF_CLK) begin
		if (!RESET_N) begin
			state_q  <= ST_CODE0;
			cnt_q    <= 4'h0;
			recov_q  <= `RECOVERY_RESET;
			shadow_q <= `RECOVERY_RESET;
			bad_q    <= 1'b0;
			flag_q   <= `FLAG_OK;
			TX_DATA  <= 8'h00;
			TX_VALID <= 1'b0;
			frames_q <= 8'h00;
		end else if (CLK_EN) begin
			case (state_q)
				// hunt for the leading digit
				ST_CODE0: begin
					if (RX_VALID && RX_DATA == `CODE_DIGIT_1) begin
						state_q <= ST_CODE1;
					end
				end

				// second code digit picks the frame
				ST_CODE1: begin
					if (RX_VALID) begin
						cnt_q <= 4'h0;
						bad_q <= 1'b0;
						shadow_q <= recov_q;
						if (RX_DATA == `CODE_SET_LO) begin
							state_q <= ST_SETD;
						end else if (RX_DATA == `CODE_QRY_LO) begin
							state_q <= ST_QRYD;
						end else if (RX_DATA == `CODE_DIGIT_1) begin
							state_q <= ST_CODE1;
						end else begin
							state_q <= ST_CODE0;
						end
					end
				end

				// twelve data bytes of a set frame
				ST_SETD: begin
					if (RX_VALID) begin
						if (sep_slot) begin
							if (RX_DATA != `VAL_SEPARATOR) begin
								bad_q <= 1'b1;
							end
						end else if (!val_ok) begin
							bad_q <= 1'b1;
						end else begin
							shadow_q <= shadow_d;
						end
						if (cnt_q == `SET_DATA_LEN - 4'h1) begin
							cnt_q   <= 4'h0;
							state_q <= ST_RESP;
							frames_q <= frames_q + 8'h01;
							// keep store on refusal
							flag_q <= flag_d;
							if (flag_d == `FLAG_OK) begin
								recov_q <= shadow_d;
							end
						end else begin
							cnt_q <= cnt_q + 4'h1;
						end
					end
				end

				// single dummy byte of a query
				ST_QRYD: begin
					if (RX_VALID) begin
						cnt_q    <= 4'h0;
						frames_q <= frames_q + 8'h01;
						if (RX_DATA == `QRY_DUMMY) begin
							flag_q  <= `FLAG_OK;
							state_q <= ST_RESP;
						end else begin
							state_q <= ST_CODE0;
						end
					end
				end

				// fifteen byte answer
				ST_RESP: begin
					// one byte per accepted handshake
					if (!TX_VALID || TX_READY) begin
						if (TX_VALID && cnt_q == `RSP_FRAME_LEN) begin
							TX_VALID <= 1'b0;
							cnt_q    <= 4'h0;
							state_q  <= ST_CODE0;
						end else if (cnt_q != `RSP_FRAME_LEN) begin
							TX_DATA  <= rsp_byte;
							TX_VALID <= 1'b1;
							cnt_q    <= cnt_q + 4'h1;
						end else begin
							TX_VALID <= 1'b0;
							cnt_q    <= 4'h0;
							state_q  <= ST_CODE0;
						end
					end
				end

				// stray codes go back to hunting
				default: begin
					state_q <= ST_CODE0;
				end
			endcase
		end
	end

	// ****************************************************************
	// output restore after power return
	// ****************************************************************
	always @(posedge REF_CLK) begin
		if (!RESET_N) begin
			OUTPUTS   <= 10'h000;
			pg_prev_q <= 1'b1;
		end else if (CLK_EN) begin
			pg_prev_q <= pg_sync;
			if (pg_rise) begin
				OUTPUTS <= (out_state_q & recov_q) | (default_q & ~recov_q);
			end else if (pg_sync) begin
				OUTPUTS <= out_state_q;
			end else begin
				OUTPUTS <= 10'h000;
			end
		end
	end

	// ****************************************************************
	// register port writes
	// ****************************************************************
	always @(posedge REF_CLK) begin
		if (!RESET_N) begin
			out_state_q <= 10'h000;
			default_q   <= 10'h000;
			setup_reg_q <= 1'b0;
			use_pin_q   <= 1'b1;
		end else if (CLK_EN) begin
			// held state, replaced by the restore value on power return
			if (pg_rise) begin
				out_state_q <= (out_state_q & recov_q) | (default_q & ~recov_q);
			end else if (REG_WR && REG_ADDR == `REG_OUT_STATE) begin
				out_state_q <= REG_WDATA;
			end
			// default state of disabled outputs
			if (REG_WR && REG_ADDR == `REG_RECOVERY) begin
				default_q <= REG_WDATA;
			end
			// mode source and register mode bit
			if (REG_WR && REG_ADDR == `REG_MODE) begin
				setup_reg_q <= REG_WDATA[0];
				use_pin_q   <= REG_WDATA[1];
			end
		end
	end

	// ****************************************************************
	// register port reads
	// ****************************************************************
	always @(posedge REF_CLK) begin
		if (!RESET_N) begin
			REG_RDATA <= 10'h000;
		end else if (CLK_EN) begin
			// read data stands one cycle, zero otherwise
			if (REG_RD) begin
				case (REG_ADDR)
					`REG_RECOVERY:  REG_RDATA <= recov_q;
					`REG_OUT_STATE: REG_RDATA <= out_state_q;
					`REG_MODE:      REG_RDATA <= {7'h00, setting_mode, use_pin_q, setup_reg_q};
					`REG_STATUS:    REG_RDATA <= {2'h0, flag_q};
					`REG_COUNT:     REG_RDATA <= {2'h0, frames_q};
					default:        REG_RDATA <= 10'h000;
				endcase
			end else begin
				REG_RDATA <= 10'h000;
			end
		end
	end
endmodule

/* common/recovery_cmd_map.vh */
`ifndef RECOVERY_CMD_MAP_VH
`define RECOVERY_CMD_MAP_VH

// ****************************************************************
// command and response codes
// ****************************************************************
`define CODE_DIGIT_1      8'h31
`define CODE_SET_LO       8'h34
`define CODE_RSP_LO       8'h35
`define CODE_QRY_LO       8'h36
`define SET_DATA_LEN      4'hC
`define RSP_DATA_LEN      4'hD
`define QRY_DUMMY         8'h30

// ****************************************************************
// data field values
// ****************************************************************
`define VAL_ENABLE        8'h31
`define VAL_DISABLE       8'h32
`define VAL_SEPARATOR     8'h2C
`define FLAG_OK           8'h30
`define FLAG_RUN_MODE     8'h31
`define FLAG_FAIL         8'h39
`define SEP_POS_A         4'h4
`define SEP_POS_B         4'h9
`define NUM_OUTPUTS       10
`define RECOVERY_RESET    10'h3FF

// ****************************************************************
// response frame length, code bytes plus data bytes
// ****************************************************************
`define RSP_FRAME_LEN     4'hF

// ****************************************************************
// register port offsets
// ****************************************************************
`define REG_RECOVERY      4'h0
`define REG_OUT_STATE     4'h1
`define REG_MODE          4'h2
`define REG_STATUS        4'h3
`define REG_COUNT         4'h4

`endif

/* hdl/sync2.v */
`timescale 1ns/10ps
module sync2 #(
	parameter W = 1
) (
	input  wire         clk,
	input  wire         ce,
	input  wire [W-1:0] d,
	output reg  [W-1:0] q
);
	reg [W-1:0] meta_q;

	// ****************************************************************
	// two stage synchroniser
	// ****************************************************************
	always @(posedge clk) begin
		if (ce) begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule

/* hdl/resp_builder.v */
`timescale 1ns/10ps
`include "recovery_cmd_map.vh"
module resp_builder (
	input  wire [3:0] idx,
	input  wire [7:0] flag,
	input  wire [9:0] recov,
	output reg  [7:0] byte_out
);
	reg [3:0] slot;

	// ****************************************************************
	// response byte at position idx
	// ****************************************************************
	always @* begin
		slot = 4'h0;
		byte_out = 8'h00;
		if (idx == 4'h0) begin
			byte_out = `CODE_DIGIT_1;
		end else if (idx == 4'h1) begin
			byte_out = `CODE_RSP_LO;
		end else if (idx == 4'h2) begin
			byte_out = flag;
		end else begin
			slot = idx - 4'h3;
			if (slot == `SEP_POS_A || slot == `SEP_POS_B) begin
				byte_out = `VAL_SEPARATOR;
			end else begin
				if (slot < `SEP_POS_A) begin
					byte_out = recov[slot] ? `VAL_ENABLE : `VAL_DISABLE;
				end else if (slot < `SEP_POS_B) begin
					byte_out = recov[slot - 4'h1] ? `VAL_ENABLE : `VAL_DISABLE;
				end else begin
					byte_out = recov[slot - 4'h2] ? `VAL_ENABLE : `VAL_DISABLE;
				end
			end
		end
	end
endmodule

/* bench/recovery_chk.sv */
`timescale 1ns/10ps
// ****
// response framing checker
// ****
module recovery_chk (
	input wire       REF_CLK,
	input wire       RESET_N,
	input wire       CLK_EN,
	input wire [7:0] TX_DATA,
	input wire       TX_VALID,
	input wire       TX_READY,
	input wire       POWER_GOOD_PIN,
	input wire [9:0] OUTPUTS
);
	reg [3:0] n_q;
	// byte position inside the response
	always @(posedge REF_CLK)
		if (!RESET_N)
			n_q <= 4'h0;
		else if (CLK_EN && TX_VALID && TX_READY)
			n_q <= (n_q == 4'hE) ? 4'h0 : n_q + 4'h1;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RESET_N);
	first_code_a: assert property (TX_VALID && n_q == 4'h0 |-> TX_DATA == 8'h31)
		else $error("first code byte wrong");
	second_code_a: assert property (TX_VALID && n_q == 4'h1 |-> TX_DATA == 8'h35)
		else $error("second code byte wrong");
	flag_byte_a: assert property (TX_VALID && n_q == 4'h2 |->
		TX_DATA inside {8'h30, 8'h31, 8'h39}) else $error("flag byte wrong");
	sep_byte_a: assert property (TX_VALID && (n_q == 4'h7 || n_q == 4'hC) |->
		TX_DATA == 8'h2C) else $error("separator wrong");
	value_byte_a: assert property (TX_VALID && n_q > 4'h2 && n_q != 4'h7 && n_q != 4'hC |->
		TX_DATA inside {8'h31, 8'h32}) else $error("setting byte wrong");
	frame_len_a: assert property ($fell(TX_VALID) |-> n_q == 4'h0)
		else $error("response length wrong");
	hold_tx_a: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
		else $error("response byte dropped");
	pwr_low_a: assert property (!POWER_GOOD_PIN [*5] |=> OUTPUTS == 10'h000)
		else $error("outputs driven without power");
endmodule
bind recovery_cmd recovery_chk chk (.REF_CLK, .RESET_N, .CLK_EN, .TX_DATA, .TX_VALID,
	.TX_READY, .POWER_GOOD_PIN, .OUTPUTS);

/* bench/host_model.sv */
`timescale 1ns/10ps
// ****
// remote host
// ****
module host_model (
	input  wire       clk,
	output reg  [7:0] rx_data,
	output reg        rx_valid,
	input  wire [7:0] tx_data,
	input  wire       tx_valid,
	output reg        tx_ready
);
	logic [7:0] got[$];
	initial begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
		tx_ready = 1'b0;
	end
	// collect answer bytes, stalling at random
	always @(posedge clk) begin
		if (tx_valid && tx_ready)
			got.push_back(tx_data);
		tx_ready <= 1'($urandom_range(1));
	end
	// bytes back to back, line inverted once released
	task automatic send(input logic [7:0] b[$]);
		foreach (b[i]) begin
			@(posedge clk);
			rx_data <= b[i];
			rx_valid <= 1'b1;
		end
		@(posedge clk);
		rx_valid <= 1'b0;
		rx_data <= ~rx_data;
	endtask
endmodule

/* bench/tb.sv */
`timescale 1ns/10ps
module tb;
	logic       clk, rst_n, setup, pwr, reg_wr, reg_rd, tx_valid, rx_valid, tx_ready, reg_run;
	logic [3:0] reg_addr;
	logic [9:0] reg_wdata, reg_rdata, outs, recov, rv, hs, ds;
	logic [7:0] tx_data, rx_data;
	logic [7:0] f[$];
	int         n_mismatch, n_compared, cyc, n_frames;
	int         bad_pos[4] = '{0, 4, 9, 11};
	recovery_cmd uut (.REF_CLK(clk), .RESET_N(rst_n), .CLK_EN(1'b1), .RX_DATA(rx_data),
		.RX_VALID(rx_valid), .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready),
		.SETUP_MODE_PIN(setup), .POWER_GOOD_PIN(pwr), .OUTPUTS(outs), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata));
	host_model h (.clk(clk), .rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready));
	// ****
	// model and helpers
	// ****
	function automatic logic [7:0] dv(int j, logic [9:0] r);
		if (j == 4 || j == 9)
			return 8'h2C;
		return r[j - (j > 4) - (j > 9)] ? 8'h31 : 8'h32;
	endfunction
	task automatic chk(string s, logic [9:0] seen, logic [9:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", s, exp, seen);
		end
	endtask
	task automatic wr(logic [3:0] a, logic [9:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(logic [3:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
	endtask
	// send frame f, compare the answer with the model
	task automatic cmd(logic [7:0] fl, int len);
		logic [7:0] e;
		n_frames++;
		h.got = {};
		h.send(f);
		for (int i = 0; i < 300 && (h.got.size() < len || (len == 0 && i < 40)); i++)
			@(posedge clk);
		chk("resp length", 10'(h.got.size()), 10'(len));
		foreach (h.got[i]) begin
			e = i == 0 ? 8'h31 : i == 1 ? 8'h35 : i == 2 ? fl : dv(i - 3, recov);
			chk("resp byte", h.got[i], e);
		end
	endtask
	task automatic qry(logic [7:0] d);
		f = {8'h31, 8'h36, d};
		cmd(8'h30, d == 8'h30 ? 15 : 0);
	endtask
	task automatic set_cmd(logic [9:0] r, int bad);
		logic [7:0] fl;
		f = {8'h31, 8'h34};
		for (int j = 0; j < 12; j++)
			f.push_back(dv(j, r));
		if (bad >= 0)
			f[bad + 2] = 8'h33;
		fl = (!setup || reg_run) ? 8'h31 : bad >= 0 ? 8'h39 : 8'h30;
		if (fl == 8'h30)
			recov = r;
		cmd(fl, 15);
		rd(4'h3);
		chk("last flag", rv, {2'h0, fl});
		qry(8'h30);
	endtask
	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ****
	// clock, timeout, sequence
	// ****
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	initial begin
		{rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		setup = 1'b1;
		pwr = 1'b1;
		recov = 10'h3FF;
		reg_run = 1'b0;
		void'($urandom(94));
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd(4'h0);
		chk("recov reset", rv, 10'h3FF);
		qry(8'h30);
		qry(8'h31);
		for (int k = 0; k < 4; k++)
			set_cmd(10'($urandom), -1);
		foreach (bad_pos[b])
			set_cmd(10'($urandom), bad_pos[b]);
		setup <= 1'b0;
		repeat (4) @(posedge clk);
		set_cmd(~recov, -1);
		setup <= 1'b1;
		wr(4'h2, 10'h000);
		reg_run = 1'b1;
		rd(4'h2);
		chk("mode reg", rv, 10'h000);
		set_cmd(~recov, -1);
		wr(4'h2, 10'h002);
		reg_run = 1'b0;
		rd(4'h2);
		chk("mode pin", rv, 10'h006);
		hs = 10'($urandom);
		ds = 10'($urandom);
		wr(4'h1, hs);
		wr(4'h0, ds);
		rd(4'hF);
		chk("unmapped", rv, 10'h000);
		pwr <= 1'b0;
		repeat (8) @(posedge clk);
		#1;
		chk("outputs off", outs, 10'h000);
		pwr <= 1'b1;
		repeat (8) @(posedge clk);
		#1;
		chk("outputs back", outs, (hs & recov) | (ds & ~recov));
		rd(4'h4);
		chk("frame count", rv, 10'(n_frames));
		tally_and_finish();
	end
endmodule
